// file: rtl/spi_ctl_pkg.sv
// constants, field positions and carrier types for the spi control block
// assumes an apb master on the system clock and external spi parties on pins
package spi_ctl_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] off_data = 8'h00;
  localparam logic [7:0] off_ctrl = 8'h04;
  localparam logic [7:0] off_count = 8'h08;
  localparam logic [7:0] off_select_timing = 8'h10;
  localparam logic [7:0] off_sck_clock_config = 8'h14;
  localparam logic [7:0] off_fifo_dma_control = 8'h1c;
  localparam logic [7:0] off_irq_flags = 8'h20;
  localparam logic [7:0] off_irq_enables = 8'h24;
  localparam logic [7:0] off_wake_flags = 8'h28;
  localparam logic [7:0] off_wake_enables = 8'h2c;
  localparam logic [7:0] off_status = 8'h30;
  // ==========================================================
  // field positions
  localparam int ctrl_role_bit = 1;
  localparam int ctrl_multi_bit = 2;
  localparam int ctrl_start_bit = 5;
  localparam int rx_dma_en_bit = 31;
  localparam int rx_flush_bit = 23;
  localparam int rx_fifo_en_bit = 22;
  localparam int tx_dma_en_bit = 15;
  localparam int tx_flush_bit = 7;
  localparam int tx_fifo_en_bit = 6;
  localparam int fl_recv_under = 15;
  localparam int fl_recv_over = 14;
  localparam int fl_send_under = 13;
  localparam int fl_send_over = 12;
  localparam int fl_done = 11;
  localparam int fl_abort = 9;
  localparam int fl_fault = 8;
  localparam int fl_sel_off = 5;
  localparam int fl_sel_on = 4;
  localparam int fl_rx_full = 3;
  localparam int fl_rx_thd = 2;
  localparam int fl_send_queue_empty_flag = 1;
  localparam int fl_tx_thd = 0;
  // ==========================================================
  // masks, reset values and sizes
  localparam logic [15:0] flags_valid = 16'hfb3f;
  localparam logic [15:0] flags_tx_group = 16'h3003;
  localparam logic [4:0] tx_thd_reset = 5'h10;
  localparam logic [8:0] span_zero = 9'h100;
  localparam logic [3:0] max_prescale = 4'h8;
  localparam logic [5:0] fifo_depth = 6'h20;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;
  typedef struct packed {
    logic sck_in;
    logic ss_in_n;
    logic mosi_in;
    logic miso_in;
  } pins_in_s;
  typedef struct packed {
    logic sck_out;
    logic sck_oe_n;
    logic ss_out_n;
    logic ss_oe_n;
    logic mosi_out;
    logic mosi_oe_n;
    logic miso_out;
    logic miso_oe_n;
  } pins_out_s;
  typedef enum logic [2:0] {
    st_idle, st_lead, st_load, st_low, st_high, st_store, st_hold, st_gap
  } mst_e;
endpackage : spi_ctl_pkg

// file: rtl/spi_timing_fifo_irq_control.sv
// spi port control: select timing, sck divider, fifos, dma, flags
// assumes apb on clk, pins asynchronous to clk, 8-bit characters, mode 0
`timescale 1ns/1ps
`default_nettype none
module spi_timing_fifo_irq_control
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register bus
  input wire spi_ctl_pkg::apb_req_s apb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // serial pins
  input wire spi_ctl_pkg::pins_in_s pins_in,
  output spi_ctl_pkg::pins_out_s pins_out,
  // requests
  output logic dma_rx_req,
  output logic dma_tx_req,
  output logic irq,
  output logic wake_req
);
  import spi_ctl_pkg::*;

  typedef struct packed {
    logic [23:0] sel_time;
    logic [3:0] clk_exp;
    logic [7:0] sck_up_count;
    logic [7:0] sck_down_count;
    logic rx_dma_en;
    logic rx_fifo_en;
    logic [4:0] rx_thd;
    logic tx_dma_en;
    logic tx_fifo_en;
    logic [4:0] tx_thd;
    logic [15:0] flags;
    logic [15:0] ien;
    logic [3:0] wkfl;
    logic [3:0] wken;
    logic role;
    logic multi;
    logic [15:0] num_char;
    logic [31:0][7:0] rx_mem;
    logic [31:0][7:0] tx_mem;
    logic [4:0] rx_wp;
    logic [4:0] rx_rp;
    logic [5:0] rx_cnt;
    logic [4:0] tx_wp;
    logic [4:0] tx_rp;
    logic [5:0] tx_cnt;
    mst_e st;
    logic [8:0] tm;
    logic [7:0] pre;
    logic [7:0] ph;
    logic [7:0] sh;
    logic mi;
    logic [2:0] bits;
    logic [15:0] chars;
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] filt;
    logic [3:0] prev;
    logic [7:0] sl_rx;
    logic [7:0] sl_tx;
    logic [2:0] sl_bits;
    logic sl_act;
    logic [31:0] rdata;
    logic err;
    logic rxq;
    logic txq;
    logic irq;
    logic wake;
  } state_s;

  state_s r;
  state_s n;

  // zero in a timing field stands for 256 cycles
  function automatic logic [8:0] span(input logic [7:0] v);
    span = (v == 8'h00) ? span_zero : {1'b0, v};
  endfunction : span

  // zero count means no duty control, one tick per phase
  function automatic logic [7:0] eff(input logic [7:0] v);
    eff = (v == 8'h00) ? 8'h01 : v;
  endfunction : eff

  logic setup;
  logic access;
  logic [15:0] set;
  logic [15:0] clr;
  logic [3:0] exp_c;
  logic tick;
  logic rx_push;
  logic [7:0] rx_din;
  logic rx_pop;
  logic tx_push;
  logic tx_pop;
  logic [7:0] tx_head;
  logic sck_rise;
  logic sck_fall;
  logic ss_on;
  logic ss_off;

  // zero wait state slave, read data captured in setup
  assign pready = 1'b1;
  assign setup = apb.psel & ~apb.penable;
  assign access = apb.psel & apb.penable;
  assign prdata = r.rdata;
  assign pslverr = r.err;
  assign dma_rx_req = r.rxq;
  assign dma_tx_req = r.txq;
  assign irq = r.irq;
  assign wake_req = r.wake;

  // ==========================================================
  // pin outputs
  always_comb
  begin
    pins_out.sck_out = (r.st == st_high);
    pins_out.sck_oe_n = ~r.role;
    // in multi master mode the select pin becomes an input
    pins_out.ss_out_n = ~(r.st inside {st_lead, st_load, st_low, st_high, st_store, st_hold});
    pins_out.ss_oe_n = ~(r.role & ~r.multi);
    pins_out.mosi_out = r.sh[7];
    pins_out.mosi_oe_n = ~r.role;
    pins_out.miso_out = r.sl_tx[7];
    pins_out.miso_oe_n = ~(~r.role & r.sl_act);
  end

  // ==========================================================
  // next state
  always_comb
  begin
    n = r;
    set = 16'h0000;
    clr = 16'h0000;
    rx_push = 1'b0;
    rx_din = 8'h00;
    rx_pop = 1'b0;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    tx_head = r.tx_mem[r.tx_rp];
    exp_c = (r.clk_exp > max_prescale) ? max_prescale : r.clk_exp;
    tick = (r.pre == 8'((9'h001 << exp_c) - 9'h001));
    n.pre = tick ? 8'h00 : 8'(r.pre + 8'h01);

    // three stage pin sync, a change counts once stages two and three agree
    n.s1 = pins_in;
    n.s2 = r.s1;
    n.s3 = r.s2;
    for (int i = 0; i < 4; i++)
    begin
      if (r.s2[i] == r.s3[i])
        n.filt[i] = r.s2[i];
    end
    n.prev = r.filt;
    sck_rise = r.filt[3] & ~r.prev[3];
    sck_fall = ~r.filt[3] & r.prev[3];
    ss_on = ~r.filt[2] & r.prev[2];
    ss_off = r.filt[2] & ~r.prev[2];

    // ========================================================
    // register bus
    n.err = 1'b0;
    if (setup)
    begin
      n.err = ~(apb.paddr[7:2] <= 6'h0c && apb.paddr[7:2] != 6'h03
        && apb.paddr[1:0] == 2'b00);
      case (apb.paddr)
        off_data: n.rdata = {24'h0, r.rx_mem[r.rx_rp]};
        off_ctrl: n.rdata = 32'({r.multi, r.role, 1'b0}) << 0;
        off_count: n.rdata = {16'h0, r.num_char};
        off_select_timing: n.rdata = {8'h00, r.sel_time};
        off_sck_clock_config:
          n.rdata = {12'h000, r.clk_exp, r.sck_up_count, r.sck_down_count};
        off_fifo_dma_control:
          n.rdata = {r.rx_dma_en, 1'b0, r.rx_cnt, 1'b0, r.rx_fifo_en, 1'b0, r.rx_thd,
            r.tx_dma_en, 1'b0, r.tx_cnt, 1'b0, r.tx_fifo_en, 1'b0, r.tx_thd};
        off_irq_flags: n.rdata = {16'h0, r.flags};
        off_irq_enables: n.rdata = {16'h0, r.ien};
        off_wake_flags: n.rdata = {28'h0, r.wkfl};
        off_wake_enables: n.rdata = {28'h0, r.wken};
        off_status: n.rdata = {31'h0, (r.st != st_idle) | r.sl_act};
        default: n.rdata = 32'h0000_0000;
      endcase
    end
    if (access && apb.pwrite)
    begin
      case (apb.paddr)
        off_data:
        begin
          if (r.tx_cnt == fifo_depth)
            set[fl_send_over] = 1'b1;
          else if (r.tx_fifo_en)
            tx_push = 1'b1;
        end
        off_ctrl:
        begin
          n.role = apb.pwdata[ctrl_role_bit];
          n.multi = apb.pwdata[ctrl_multi_bit];
          if (apb.pwdata[ctrl_start_bit] && apb.pwdata[ctrl_role_bit] && r.st == st_idle)
          begin
            n.st = st_lead;
            n.tm = 9'(span(r.sel_time[7:0]) - 9'h001);
            n.chars = 16'h0000;
          end
        end
        off_count: n.num_char = apb.pwdata[15:0];
        off_select_timing: n.sel_time = apb.pwdata[23:0];
        off_sck_clock_config:
        begin
          n.clk_exp = apb.pwdata[19:16];
          n.sck_up_count = apb.pwdata[15:8];
          n.sck_down_count = apb.pwdata[7:0];
        end
        off_fifo_dma_control:
        begin
          // dropping a dma enable also drops its request below
          n.rx_dma_en = apb.pwdata[rx_dma_en_bit];
          n.rx_fifo_en = apb.pwdata[rx_fifo_en_bit];
          n.rx_thd = apb.pwdata[20:16];
          n.tx_dma_en = apb.pwdata[tx_dma_en_bit];
          n.tx_fifo_en = apb.pwdata[tx_fifo_en_bit];
          n.tx_thd = apb.pwdata[4:0];
        end
        off_irq_flags: clr = apb.pwdata[15:0] & flags_valid;
        off_irq_enables: n.ien = apb.pwdata[15:0] & flags_valid;
        off_wake_flags: n.wkfl = r.wkfl & ~apb.pwdata[3:0];
        off_wake_enables: n.wken = apb.pwdata[3:0];
        default: ;
      endcase
    end
    if (access && !apb.pwrite && apb.paddr == off_data)
    begin
      if (r.rx_cnt == 6'h00)
        set[fl_recv_under] = 1'b1;
      else
        rx_pop = 1'b1;
    end

    // ========================================================
    // master sequencer
    case (r.st)
      st_idle: ;
      // lead time before first sck edge
      st_lead:
      begin
        n.tm = 9'(r.tm - 9'h001);
        if (r.tm == 9'h000)
          n.st = st_load;
      end
      st_load:
      begin
        if (r.chars == r.num_char)
        begin
          n.st = st_hold;
          n.tm = 9'(span(r.sel_time[15:8]) - 9'h001);
        end
        // master waits on empty transmit fifo
        else if (r.tx_cnt != 6'h00)
        begin
          tx_pop = 1'b1;
          n.sh = tx_head;
          n.bits = 3'h0;
          n.ph = 8'h00;
          n.pre = 8'h00;
          n.st = st_low;
        end
      end
      st_low:
      begin
        if (tick)
        begin
          n.ph = 8'(r.ph + 8'h01);
          if (8'(r.ph + 8'h01) == eff(r.sck_down_count))
          begin
            n.ph = 8'h00;
            // miso taken at the rise, shift at the fall keeps mosi still under sck
            n.mi = r.filt[0];
            n.st = st_high;
          end
        end
      end
      st_high:
      begin
        if (tick)
        begin
          n.ph = 8'(r.ph + 8'h01);
          if (8'(r.ph + 8'h01) == eff(r.sck_up_count))
          begin
            n.ph = 8'h00;
            n.sh = {r.sh[6:0], r.mi};
            n.bits = 3'(r.bits + 3'h1);
            n.st = (r.bits == 3'h7) ? st_store : st_low;
          end
        end
      end
      st_store:
      begin
        // master holds sck while the enabled receive fifo is full
        if (!(r.rx_fifo_en && r.rx_cnt == fifo_depth))
        begin
          rx_push = r.rx_fifo_en;
          rx_din = r.sh;
          n.chars = 16'(r.chars + 16'h0001);
          n.st = st_load;
        end
      end
      st_hold:
      begin
        n.tm = 9'(r.tm - 9'h001);
        if (r.tm == 9'h000)
        begin
          n.st = st_gap;
          n.tm = 9'(span(r.sel_time[23:16]) - 9'h001);
          set[fl_done] = 1'b1;
        end
      end
      // select inactive gap before next start
      st_gap:
      begin
        n.tm = 9'(r.tm - 9'h001);
        if (r.tm == 9'h000)
          n.st = st_idle;
      end
      default: n.st = st_idle;
    endcase
    // leaving master role drops the timed sequence
    if (!n.role)
      n.st = st_idle;

    // ========================================================
    // slave side, select input active low
    if (!r.role)
    begin
      if (ss_on)
      begin
        set[fl_sel_on] = 1'b1;
        n.sl_act = 1'b1;
        n.sl_bits = 3'h0;
        // underrun when a character must go out
        if (r.tx_cnt == 6'h00)
        begin
          set[fl_send_under] = 1'b1;
          n.sl_tx = 8'h00;
        end
        else
        begin
          tx_pop = 1'b1;
          n.sl_tx = tx_head;
        end
      end
      else if (ss_off && r.sl_act)
      begin
        set[fl_sel_off] = 1'b1;
        n.sl_act = 1'b0;
        if (r.sl_bits != 3'h0)
          set[fl_abort] = 1'b1;
      end
      else if (r.sl_act && sck_rise)
      begin
        n.sl_rx = {r.sl_rx[6:0], r.filt[1]};
        n.sl_bits = 3'(r.sl_bits + 3'h1);
        if (r.sl_bits == 3'h7)
        begin
          if (r.rx_cnt == fifo_depth)
            set[fl_recv_over] = 1'b1;
          else
          begin
            rx_push = r.rx_fifo_en;
            rx_din = {r.sl_rx[6:0], r.filt[1]};
          end
        end
      end
      else if (r.sl_act && sck_fall)
      begin
        if (r.sl_bits != 3'h0)
          n.sl_tx = {r.sl_tx[6:0], 1'b0};
        else if (r.tx_cnt == 6'h00)
          set[fl_send_under] = 1'b1;
        else
        begin
          tx_pop = 1'b1;
          n.sl_tx = tx_head;
        end
      end
    end
    else
      n.sl_act = 1'b0;

    // select input asserted while master in multi master mode
    if (r.role && r.multi && !r.filt[2])
      set[fl_fault] = 1'b1;

    // ========================================================
    // fifos
    if (rx_push)
    begin
      n.rx_mem[r.rx_wp] = rx_din;
      n.rx_wp = 5'(r.rx_wp + 5'h01);
    end
    if (rx_pop)
      n.rx_rp = 5'(r.rx_rp + 5'h01);
    n.rx_cnt = 6'(r.rx_cnt + {5'h00, rx_push} - {5'h00, rx_pop});
    if (tx_push)
    begin
      n.tx_mem[r.tx_wp] = apb.pwdata[7:0];
      n.tx_wp = 5'(r.tx_wp + 5'h01);
    end
    if (tx_pop)
      n.tx_rp = 5'(r.tx_rp + 5'h01);
    n.tx_cnt = 6'(r.tx_cnt + {5'h00, tx_push} - {5'h00, tx_pop});
    if (access && apb.pwrite && apb.paddr == off_fifo_dma_control)
    begin
      if (apb.pwdata[rx_flush_bit])
      begin
        n.rx_wp = 5'h00;
        n.rx_rp = 5'h00;
        n.rx_cnt = 6'h00;
      end
      // transmit flush clears the transmit flags too
      if (apb.pwdata[tx_flush_bit])
      begin
        n.tx_wp = 5'h00;
        n.tx_rp = 5'h00;
        n.tx_cnt = 6'h00;
        clr = clr | flags_tx_group;
      end
    end

    // ========================================================
    // levels, flags, requests
    set[fl_rx_full] = set[fl_rx_full] | (r.rx_cnt == fifo_depth);
    set[fl_rx_thd] = r.rx_cnt > {1'b0, r.rx_thd};
    set[fl_send_queue_empty_flag] = r.tx_cnt == 6'h00;
    set[fl_tx_thd] = r.tx_cnt < {1'b0, r.tx_thd};
    if (r.rx_cnt < {1'b0, r.rx_thd})
      clr[fl_rx_thd] = 1'b1;
    if (r.tx_cnt > {1'b0, r.tx_thd})
      clr[fl_tx_thd] = 1'b1;
    // a set in the same cycle as a clear wins
    n.flags = ((r.flags & ~clr) | set) & flags_valid;
    n.wkfl = n.wkfl | set[3:0];
    n.rxq = n.rx_dma_en & set[fl_rx_thd];
    n.txq = n.tx_dma_en & set[fl_tx_thd];
    n.irq = |(r.flags & r.ien);
    n.wake = |(r.wkfl & r.wken);

    if (rst)
    begin
      n = '0;
      n.tx_thd = tx_thd_reset;
      n.flags[fl_send_queue_empty_flag] = 1'b1;
      n.s1[2] = 1'b1;
      n.s2[2] = 1'b1;
      n.s3[2] = 1'b1;
      n.filt[2] = 1'b1;
      n.prev[2] = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    r <= n;
  end

endmodule : spi_timing_fifo_irq_control
`default_nettype wire

// file: bench/spi_ctl_checker.sv
// port assertions for the spi control block
// assumes a bind onto the block; settings mirrored from apb writes
`timescale 1ns/1ps
`default_nettype none
module spi_ctl_checker
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // watched ports
  input wire spi_ctl_pkg::apb_req_s apb,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire spi_ctl_pkg::pins_in_s pins_in,
  input wire spi_ctl_pkg::pins_out_s pins_out,
  input wire logic dma_rx_req,
  input wire logic dma_tx_req,
  input wire logic irq,
  input wire logic wake_req
);
  import spi_ctl_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ========
  // mirrored settings
  logic wr, role, rx_en, tx_en, ien_any, wen_any;
  logic [23:0] tim;
  logic [19:0] ckc;
  logic [15:0] ien, wen;
  logic [3:0] ex;
  logic [8:0] s_lead, s_hold, s_gap;
  logic [11:0] e_hi, e_lo, c_lead, c_hold, c_gap, c_hi;
  assign wr = apb.psel && apb.penable && apb.pwrite;
  assign ex = (ckc[19:16] > max_prescale) ? max_prescale : ckc[19:16];
  assign e_hi = ((ckc[15:8] == 8'h00) ? 12'h001 : {4'h0, ckc[15:8]}) << ex;
  assign e_lo = ((ckc[7:0] == 8'h00) ? 12'h001 : {4'h0, ckc[7:0]}) << ex;
  assign s_lead = (tim[7:0] == 8'h00) ? span_zero : {1'b0, tim[7:0]};
  assign s_hold = (tim[15:8] == 8'h00) ? span_zero : {1'b0, tim[15:8]};
  assign s_gap = (tim[23:16] == 8'h00) ? span_zero : {1'b0, tim[23:16]};
  assign ien_any = |ien;
  assign wen_any = |wen;
  function automatic logic [11:0] sat(input logic [11:0] v);
    return (v == 12'hfff) ? v : v + 12'h001;
  endfunction : sat
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      {role, rx_en, tx_en, tim, ckc, ien, wen} <= '0;
    end
    else if (wr)
    begin
      if (apb.paddr == off_ctrl) role <= apb.pwdata[ctrl_role_bit];
      if (apb.paddr == off_select_timing) tim <= apb.pwdata[23:0];
      if (apb.paddr == off_sck_clock_config) ckc <= apb.pwdata[19:0];
      if (apb.paddr == off_fifo_dma_control) rx_en <= apb.pwdata[rx_dma_en_bit];
      if (apb.paddr == off_fifo_dma_control) tx_en <= apb.pwdata[tx_dma_en_bit];
      if (apb.paddr == off_irq_enables) ien <= apb.pwdata[15:0];
      if (apb.paddr == off_wake_enables) wen <= apb.pwdata[15:0];
    end
  end
  // saturating so long idle spans never wrap
  always_ff @(posedge clk)
  begin
    c_lead <= (rst || pins_out.ss_out_n) ? 12'h000 : sat(c_lead);
    c_hold <= (rst || pins_out.ss_out_n || pins_out.sck_out) ? 12'h000 : sat(c_hold);
    c_gap <= rst ? 12'hfff : (pins_out.ss_out_n ? sat(c_gap) : 12'h000);
    c_hi <= (rst || !pins_out.sck_out) ? 12'h000 : sat(c_hi);
  end
  sequence sel_release;
    !pins_out.sck_out ##1 $rose(pins_out.ss_out_n);
  endsequence
  // ========
  // select and sck timing
  sel_lead_a:
    assert property ($rose(pins_out.sck_out) |-> c_lead >= {3'h0, s_lead} + e_lo)
    else $error("sck started before the lead time ran out");
  sel_hold_a:
    assert property (sel_release |-> c_hold >= {3'h0, s_hold})
    else $error("select released before the hold time ran out");
  sel_gap_a:
    assert property ($fell(pins_out.ss_out_n) |-> c_gap >= {3'h0, s_gap})
    else $error("select reasserted inside the idle gap");
  sck_high_a:
    assert property ($fell(pins_out.sck_out) |-> c_hi == e_hi)
    else $error("sck high phase has the wrong length");
  sck_low_a:
    assert property ($rose(pins_out.sck_out) |-> c_hold >= e_lo)
    else $error("sck low phase too short");
  // ========
  // role and request gating
  role_pin_a:
    assert property (role == $past(role) |-> pins_out.sck_oe_n == !role)
    else $error("sck drive does not follow the role bit");
  slave_quiet_a:
    assert property (!role && !$past(role) |-> pins_out.ss_out_n)
    else $error("select driven while in slave role");
  rx_gate_a:
    assert property (!rx_en && !$past(rx_en) |-> !dma_rx_req)
    else $error("receive dma request while disabled");
  tx_gate_a:
    assert property (!tx_en && !$past(tx_en) |-> !dma_tx_req)
    else $error("transmit dma request while disabled");
  irq_gate_a:
    assert property (!ien_any && !$past(ien_any) |-> !irq)
    else $error("interrupt with every enable off");
  wake_gate_a:
    assert property (!wen_any && !$past(wen_any) |-> !wake_req)
    else $error("wake request with every enable off");
endmodule : spi_ctl_checker
bind spi_timing_fifo_irq_control spi_ctl_checker chk_i
(
  .clk(clk),
  .rst(rst),
  .apb(apb),
  .pready(pready),
  .prdata(prdata),
  .pslverr(pslverr),
  .pins_in(pins_in),
  .pins_out(pins_out),
  .dma_rx_req(dma_rx_req),
  .dma_tx_req(dma_tx_req),
  .irq(irq),
  .wake_req(wake_req)
);
`default_nettype wire

// file: bench/spi_far_slave.sv
// behavioural spi slave on the far side, mode 0, msb first
// assumes the port is master; answers with bytes counting up from 8'h5a
`timescale 1ns/1ps
`default_nettype none
module spi_far_slave
(
  // serial side
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  output logic miso,
  // traffic seen on mosi
  output logic [15:0] got
);
  logic [7:0] sh = 8'h00;
  logic [7:0] nxt = 8'h5a;
  logic [2:0] nb = 3'h0;
  initial
  begin
    miso = 1'b0;
    got = 16'h0000;
  end
  always @(negedge ss_n)
  begin
    sh = nxt;
    nxt = nxt + 8'h01;
    nb = 3'h0;
    miso = sh[7];
  end
  always @(posedge sck)
  begin
    if (!ss_n)
    begin
      got = {got[14:0], mosi};
      nb = nb + 3'h1;
    end
  end
  // shift, or reload at a character boundary
  always @(negedge sck)
  begin
    if (!ss_n)
    begin
      sh = (nb == 3'h0) ? nxt : {sh[6:0], 1'b0};
      if (nb == 3'h0) nxt = nxt + 8'h01;
      miso = sh[7];
    end
  end
  // no pull on the line: show the inverse of the last bit
  always @(posedge ss_n) miso = ~miso;
endmodule : spi_far_slave
`default_nettype wire

// file: bench/spi_timing_fifo_irq_control_tb.sv
// self-checking bench for the spi control block
// assumes the block, its package, the bound checker and spi_far_slave
`timescale 1ns/1ps
`default_nettype none
module spi_timing_fifo_irq_control_tb;
  import spi_ctl_pkg::*;
  logic clk, rst, pready, pslverr, dma_rx_req, dma_tx_req, irq, wake_req;
  logic xsck, xss_n, xmosi, miso;
  logic [31:0] prdata;
  logic [15:0] got;
  apb_req_s apb;
  pins_in_s pins_in;
  pins_out_s pins_out;
  int mismatches = 0;
  int n_compared = 0;
  assign pins_in = {xsck, xss_n, xmosi, miso};
  spi_timing_fifo_irq_control DUT
  (
    .clk(clk),
    .rst(rst),
    .apb(apb),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .pins_in(pins_in),
    .pins_out(pins_out),
    .dma_rx_req(dma_rx_req),
    .dma_tx_req(dma_tx_req),
    .irq(irq),
    .wake_req(wake_req)
  );
  spi_far_slave far
  (
    .sck(pins_out.sck_out),
    .ss_n(pins_out.ss_out_n),
    .mosi(pins_out.mosi_out),
    .miso(miso),
    .got(got)
  );
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic tally_and_finish();
    if (mismatches == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // ========
  // apb master: hold the request until pready is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge clk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    apb.penable <= 1'b1;
    // no wait count assumed; only the watchdog ends a hang
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    e = pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    xfer(1'b0, a, 32'h0, q, e);
    chk(what, q & m, exp);
  endtask : rd
  // level outputs settle within a few cycles of a write
  task automatic pin(input string what, ref logic v, input logic exp);
    repeat (3) @(posedge clk);
    chk(what, {31'h0, v}, {31'h0, exp});
  endtask : pin
  // ========
  // scenarios
  task automatic t_reset();
    logic [31:0] q;
    logic e;
    rd("select_timing", off_select_timing, '1, 32'h0);
    rd("sck_clock_config", off_sck_clock_config, '1, 32'h0);
    rd("fifo_dma_control", off_fifo_dma_control, '1, 32'h10);
    rd("irq_flags", off_irq_flags, '1, 32'h3);
    rd("irq_enables", off_irq_enables, '1, 32'h0);
    rd("wake_enables", off_wake_enables, '1, 32'h0);
    xfer(1'b0, 8'h0c, 32'h0, q, e);
    chk("unmapped pslverr", {31'h0, e}, 32'h1);
  endtask : t_reset
  task automatic t_master();
    logic [31:0] q;
    logic e;
    int n;
    wr(off_select_timing, 32'h0005_0304);
    rd("select_timing", off_select_timing, '1, 32'h0005_0304);
    wr(off_sck_clock_config, 32'h0001_0404);
    rd("sck_clock_config", off_sck_clock_config, '1, 32'h0001_0404);
    wr(off_fifo_dma_control, 32'h0040_0050);
    wr(off_data, 32'ha5);
    wr(off_data, 32'h3c);
    rd("tx level", off_fifo_dma_control, 32'h7f00, 32'h0200);
    wr(off_count, 32'h2);
    wr(off_irq_flags, 32'hffff);
    rd("busy before start", off_status, 32'h1, 32'h0);
    wr(off_ctrl, 32'h22);
    for (n = 0; n < 20 && pins_out.ss_out_n !== 1'b0; n++) @(posedge clk);
    chk("ss_out_n", {31'h0, pins_out.ss_out_n}, 32'h0);
    for (n = 0; n < 300; n++)
    begin
      xfer(1'b0, off_status, 32'h0, q, e);
      if (q[0] === 1'b0) break;
    end
    chk("busy", {31'h0, q[0]}, 32'h0);
    chk("mosi bytes", {16'h0, got}, 32'ha53c);
    rd("done flag", off_irq_flags, 32'h800, 32'h800);
    wr(off_fifo_dma_control, 32'h8041_0050);
    pin("dma_rx_req", dma_rx_req, 1'b1);
    rd("rx thd flag", off_irq_flags, 32'h4, 32'h4);
    rd("rx level", off_fifo_dma_control, 32'h7f00_0000, 32'h0200_0000);
    wr(off_fifo_dma_control, 32'h0041_0050);
    pin("dma_rx_req", dma_rx_req, 1'b0);
    rd("rx data", off_data, 32'hff, 32'h5a);
    wr(off_fifo_dma_control, 32'h00c1_0050);
    rd("rx level", off_fifo_dma_control, 32'h7f00_0000, 32'h0);
    xfer(1'b0, off_data, 32'h0, q, e);
    rd("rx underrun", off_irq_flags, 32'h8000, 32'h8000);
    wr(off_irq_flags, 32'h8000);
    rd("rx underrun", off_irq_flags, 32'h8000, 32'h0);
  endtask : t_master
  task automatic t_tx();
    int n;
    wr(off_ctrl, 32'h0);
    wr(off_fifo_dma_control, 32'h8050);
    for (n = 0; n < 3; n++) wr(off_data, 32'(n));
    pin("dma_tx_req", dma_tx_req, 1'b1);
    rd("tx level", off_fifo_dma_control, 32'h7f00, 32'h0300);
    wr(off_irq_flags, 32'h2);
    rd("tx flags", off_irq_flags, 32'h3, 32'h1);
    wr(off_irq_enables, 32'h1000);
    for (n = 0; n < 30; n++) wr(off_data, 32'(n));
    rd("tx flags", off_irq_flags, 32'h1003, 32'h1000);
    pin("irq", irq, 1'b1);
    wr(off_wake_flags, 32'hf);
    wr(off_wake_enables, 32'h2);
    pin("wake_req", wake_req, 1'b0);
    wr(off_fifo_dma_control, 32'h8010);
    wr(off_fifo_dma_control, 32'h8090);
    rd("tx flags", off_irq_flags, 32'h1003, 32'h3);
    rd("tx level", off_fifo_dma_control, 32'h7f00, 32'h0);
    pin("irq", irq, 1'b0);
    pin("wake_req", wake_req, 1'b1);
    wr(off_fifo_dma_control, 32'h0);
    pin("dma_tx_req", dma_tx_req, 1'b0);
    wr(off_wake_enables, 32'h0);
    wr(off_irq_enables, 32'h0);
  endtask : t_tx
  task automatic t_slave();
    wr(off_irq_flags, 32'hffff);
    xss_n <= 1'b0;
    repeat (3)
    begin
      repeat (10) @(posedge clk);
      xsck <= 1'b1;
      repeat (10) @(posedge clk);
      xsck <= 1'b0;
    end
    repeat (10) @(posedge clk);
    chk("miso_oe_n", {31'h0, pins_out.miso_oe_n}, 32'h0);
    xss_n <= 1'b1;
    repeat (10) @(posedge clk);
    rd("tx underrun", off_irq_flags, 32'h2000, 32'h2000);
    rd("abort and select", off_irq_flags, 32'h230, 32'h230);
    wr(off_ctrl, 32'h6);
    xss_n <= 1'b0;
    repeat (10) @(posedge clk);
    rd("fault", off_irq_flags, 32'h100, 32'h100);
    xss_n <= 1'b1;
    wr(off_ctrl, 32'h0);
  endtask : t_slave
  // ========
  // watchdog and main sequence
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
  initial
  begin
    rst <= 1'b1;
    apb <= '0;
    xsck <= 1'b0;
    xss_n <= 1'b1;
    xmosi <= 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_master();
    t_tx();
    t_slave();
    tally_and_finish();
  end
endmodule : spi_timing_fifo_irq_control_tb
`default_nettype wire
